// >>> design/cmd_parser_regs.vh
// Constants for the remote command parser
`ifndef CMD_PARSER_REGS_VH
`define CMD_PARSER_REGS_VH

`define BUF_AW        12
`define BUF_DEPTH     13'h1000
`define SET_MAX       12'hFFF
`define RESP_MAX      16'hFFFF

`define CH_NUL        8'h00
`define CH_TAB        8'h09
`define CH_LF         8'h0A
`define CH_FF         8'h0C
`define CH_CR         8'h0D
`define CH_SPACE      8'h20
`define CH_COMMA      8'h2C
`define CH_COLON      8'h3A
`define CH_SEMI       8'h3B
`define CH_QUERY      8'h3F
`define CH_UNDER      8'h5F
`define CH_LOW_Z      8'h7A
`define CH_BANG       8'h21
`define CH_DOLLAR     8'h24
`define CH_BSLASH     8'h5C
`define CH_CARET      8'h5E
`define CH_LBRACK     8'h5B
`define CH_RBRACK     8'h5D

`define GLYPH_OMEGA   8'h80
`define GLYPH_MICRO   8'h81
`define GLYPH_SIGMA   8'h82
`define GLYPH_SLASH_O 8'h83
`define GLYPH_UP      8'h84
`define GLYPH_DEGREE  8'h85

`define TOK_KW_CHAR   4'h1
`define TOK_KW_END    4'h2
`define TOK_FLD_CHAR  4'h3
`define TOK_FLD_SEP   4'h4
`define TOK_SUB_SEP   4'h5
`define TOK_CMD_END   4'h6
`define TOK_CMD_ABORT 4'h7
`define TOK_SET_END   4'h8

`define KW_OK         2'h0
`define KW_BAD        2'h1
`define KW_PANEL      2'h2
`define KW_GPIB_ONLY  2'h3

`endif

// >>> design/cmd_char_ram.v
// Command character store with registered read data
`timescale 1ns/100ps
module cmd_char_ram (
    input  wire        clk,
    input  wire        wr_en,
    input  wire [11:0] wr_addr,
    input  wire [8:0]  wr_data,
    input  wire [11:0] rd_addr,
    output reg  [8:0]  rd_data
);
    reg [8:0] mem [0:4095];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> design/ascii_cmd_parser.v
// Remote command parser: character buffer, field splitter, response framing
`timescale 1ns/100ps
`include "cmd_parser_regs.vh"
module ascii_cmd_parser (
    input  wire        clk,
    input  wire        resetn,
    input  wire        port_is_gpib,
    input  wire [7:0]  rx_data,
    input  wire        rx_eoi,
    input  wire        rx_valid,
    output wire        rx_ready,
    output wire        tok_valid,
    input  wire        tok_ready,
    output wire [3:0]  tok_kind,
    output wire [7:0]  tok_data,
    input  wire        kw_class_valid,
    input  wire [1:0]  kw_class,
    input  wire        str_mode,
    output reg         syntax_error,
    output reg         overrun_error,
    output reg         resp_flush,
    input  wire        talk_req,
    input  wire [7:0]  resp_data,
    input  wire        resp_last,
    input  wire        resp_valid,
    output wire        resp_ready,
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_eoi,
    output reg         resp_pending,
    input  wire        gpib_remote,
    input  wire        cmd_remote,
    input  wire        panel_local_req,
    output reg         local_request,
    output reg         remote_state
);
    localparam S_IDLE  = 6'b000001;
    localparam S_FETCH = 6'b000010;
    localparam S_PROC  = 6'b000100;
    localparam S_KWAIT = 6'b001000;
    localparam S_ECMD  = 6'b010000;
    localparam S_ESET  = 6'b100000;
    localparam T_IDLE  = 4'b0001;
    localparam T_DATA  = 4'b0010;
    localparam T_CR    = 4'b0100;
    localparam T_LF    = 4'b1000;

    // Receive side
    reg  [11:0] wr_ptr;
    reg  [11:0] rd_ptr;
    reg  [12:0] fill;
    reg  [11:0] set_len;
    reg  [12:0] sets;
    reg         ins_term;
    wire [8:0]  rd_word;
    wire        rx_take = rx_valid && rx_ready;
    wire        rx_term = (rx_data == `CH_LF) || (rx_data == `CH_CR) ||
                          (rx_data == `CH_FF) || (rx_data == `CH_NUL);
    wire        wr_en   = rx_take || ins_term;
    wire        wr_end  = ins_term || rx_term;
    // Overlong sets get bit 7 forced so the decoder rejects them
    wire [7:0]  wr_char = ins_term ? `CH_LF :
                          ((set_len == `SET_MAX) ? (rx_data | 8'h80) : rx_data);
    wire        rd_take;
    wire        set_done;

    // Leave room for the terminator inserted after an EOI byte
    assign rx_ready = !ins_term && (fill < (`BUF_DEPTH - 13'h1));

    cmd_char_ram u_ram (
        .clk     (clk),
        .wr_en   (wr_en),
        .wr_addr (wr_ptr),
        .wr_data ({wr_end, wr_char}),
        .rd_addr (rd_ptr),
        .rd_data (rd_word)
    );

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr   <= 12'h000;
            fill     <= 13'h0000;
            set_len  <= 12'h000;
            sets     <= 13'h0000;
            ins_term <= 1'b0;
        end else begin
            ins_term <= rx_take && rx_eoi && !rx_term;
            if (wr_en) begin
                wr_ptr <= wr_ptr + 12'h001;
                if (wr_end) begin
                    set_len <= 12'h000;
                end else if (set_len != `SET_MAX) begin
                    set_len <= set_len + 12'h001;
                end
            end
            fill <= fill + {12'h000, wr_en} - {12'h000, rd_take};
            sets <= sets + {12'h000, wr_en && wr_end} - {12'h000, set_done};
        end
    end

    // Two-entry token buffer
    reg  [11:0] ent0;
    reg  [11:0] ent1;
    reg  [1:0]  f_cnt;
    reg         emit_v;
    reg  [3:0]  emit_k;
    reg  [7:0]  emit_d;
    wire        f_rd = tok_valid && tok_ready;
    wire [1:0]  f_pos = f_cnt - {1'b0, f_rd};
    wire        go = (f_cnt == 2'd0) || ((f_cnt == 2'd1) && !emit_v);

    assign tok_valid = (f_cnt != 2'd0);
    assign tok_kind  = ent0[11:8];
    assign tok_data  = ent0[7:0];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ent0  <= 12'h000;
            ent1  <= 12'h000;
            f_cnt <= 2'd0;
        end else begin
            if (f_rd) begin
                ent0 <= ent1;
            end
            if (emit_v) begin
                if (f_pos == 2'd0) begin
                    ent0 <= {emit_k, emit_d};
                end else begin
                    ent1 <= {emit_k, emit_d};
                end
            end
            f_cnt <= f_cnt + {1'b0, emit_v} - {1'b0, f_rd};
        end
    end

    // Decoder
    reg  [5:0] st;
    reg        sect;
    reg        kw_started;
    reg        kw_ws;
    reg        kw_query;
    reg        fld_started;
    reg        fld_ws;
    reg        cmd_has;
    reg        set_has;
    reg        skip;
    reg        err;
    reg        pend_cmd;
    reg        pend_set;
    reg        q_set;
    reg        q_acc;
    wire [7:0] c  = rd_word[7:0];
    wire       ce = rd_word[8];
    wire       is_ws = (c == `CH_SPACE) || (c == `CH_TAB) || (c == `CH_UNDER);
    wire [7:0] c_up = ((c >= 8'h61) && (c <= `CH_LOW_Z)) ? (c & 8'hDF) : c;

    assign rd_take  = (st == S_PROC) && go;
    assign set_done = (st == S_ESET) && go;

    function [7:0] glyph;
        input [7:0] ch;
        begin
            case (ch)
                `CH_BANG:   glyph = `GLYPH_OMEGA;
                `CH_DOLLAR: glyph = `GLYPH_MICRO;
                `CH_CARET:  glyph = `GLYPH_SIGMA;
                `CH_BSLASH: glyph = `GLYPH_SLASH_O;
                `CH_LBRACK: glyph = `GLYPH_UP;
                `CH_RBRACK: glyph = `GLYPH_DEGREE;
                default:    glyph = ch;
            endcase
        end
    endfunction

    task emit;
        input [3:0] k;
        input [7:0] d;
        begin
            emit_v <= 1'b1;
            emit_k <= k;
            emit_d <= d;
        end
    endtask

    task fail;
        begin
            emit(`TOK_CMD_ABORT, 8'h00);
            err          <= 1'b1;
            syntax_error <= 1'b1;
        end
    endtask

    task new_cmd;
        begin
            sect        <= 1'b0;
            kw_started  <= 1'b0;
            kw_ws       <= 1'b0;
            kw_query    <= 1'b0;
            fld_started <= 1'b0;
            fld_ws      <= 1'b0;
            cmd_has     <= 1'b0;
            skip        <= 1'b0;
        end
    endtask

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= S_IDLE;
            sect <= 1'b0;
            kw_started <= 1'b0;
            kw_ws <= 1'b0;
            kw_query <= 1'b0;
            fld_started <= 1'b0;
            fld_ws <= 1'b0;
            cmd_has <= 1'b0;
            set_has <= 1'b0;
            skip <= 1'b0;
            err <= 1'b0;
            pend_cmd <= 1'b0;
            pend_set <= 1'b0;
            q_set <= 1'b0;
            q_acc <= 1'b0;
            rd_ptr <= 12'h000;
            emit_v <= 1'b0;
            emit_k <= 4'h0;
            emit_d <= 8'h00;
            syntax_error <= 1'b0;
            overrun_error <= 1'b0;
            resp_flush <= 1'b0;
        end else begin
            emit_v <= 1'b0;
            syntax_error <= 1'b0;
            overrun_error <= 1'b0;
            resp_flush <= 1'b0;
            q_acc <= 1'b0;
            case (st)
                S_IDLE: begin
                    if (sets != 13'h0000) begin
                        st <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    st <= S_PROC;
                end
                S_PROC: begin
                    if (go) begin
                        rd_ptr <= rd_ptr + 12'h001;
                        st <= S_FETCH;
                        if (ce) begin
                            // Empty sets fall straight through to set end
                            if (err || skip || !cmd_has) begin
                                st <= S_ESET;
                            end else if (!sect) begin
                                emit(`TOK_KW_END, {7'h00, kw_query});
                                pend_cmd <= 1'b1;
                                pend_set <= 1'b1;
                                st <= S_KWAIT;
                            end else begin
                                pend_set <= 1'b1;
                                st <= S_ECMD;
                            end
                        end else if (c[7]) begin
                            if (!err) begin
                                fail;
                            end
                        end else if (err) begin
                            st <= S_FETCH;
                        end else if (c == `CH_SEMI) begin
                            if (skip) begin
                                new_cmd;
                            end else if (!cmd_has) begin
                                new_cmd;
                            end else if (!sect) begin
                                emit(`TOK_KW_END, {7'h00, kw_query});
                                pend_cmd <= 1'b1;
                                st <= S_KWAIT;
                            end else begin
                                st <= S_ECMD;
                            end
                        end else if (skip) begin
                            st <= S_FETCH;
                        end else if (!sect) begin
                            if (is_ws) begin
                                kw_ws <= kw_started;
                            end else if (c == `CH_COMMA) begin
                                if (!kw_started) begin
                                    fail;
                                end else begin
                                    emit(`TOK_KW_END, {7'h00, kw_query});
                                    st <= S_KWAIT;
                                end
                            end else if (c == `CH_COLON || kw_ws) begin
                                fail;
                            end else begin
                                emit(`TOK_KW_CHAR, c_up);
                                kw_started <= 1'b1;
                                cmd_has <= 1'b1;
                                set_has <= 1'b1;
                                kw_query <= (c == `CH_QUERY);
                            end
                        end else if (str_mode) begin
                            if ((c < `CH_SPACE) || (c > `CH_LOW_Z)) begin
                                fail;
                            end else begin
                                emit(`TOK_FLD_CHAR, glyph(c));
                            end
                        end else if (is_ws) begin
                            fld_ws <= fld_started;
                        end else if (c == `CH_COMMA) begin
                            emit(`TOK_FLD_SEP, c);
                            fld_started <= 1'b0;
                            fld_ws <= 1'b0;
                        end else if (c == `CH_COLON) begin
                            emit(`TOK_SUB_SEP, c);
                            fld_started <= 1'b0;
                            fld_ws <= 1'b0;
                        end else if (fld_ws) begin
                            fail;
                        end else begin
                            emit(`TOK_FLD_CHAR, c);
                            fld_started <= 1'b1;
                        end
                    end
                end
                S_KWAIT: begin
                    if (kw_class_valid && go) begin
                        sect <= 1'b1;
                        st <= pend_cmd ? S_ECMD : S_FETCH;
                        case (kw_class)
                            `KW_BAD: begin
                                fail;
                            end
                            `KW_PANEL: begin
                                if (port_is_gpib) begin
                                    emit(`TOK_CMD_ABORT, 8'h00);
                                    skip <= 1'b1;
                                end
                            end
                            `KW_GPIB_ONLY: begin
                                if (!port_is_gpib) begin
                                    fail;
                                end
                            end
                            default: begin
                                sect <= 1'b1;
                            end
                        endcase
                    end
                end
                S_ECMD: begin
                    if (go) begin
                        if (!err && !skip) begin
                            if (kw_query && resp_pending && !q_set) begin
                                overrun_error <= 1'b1;
                                if (port_is_gpib) begin
                                    emit(`TOK_CMD_END, 8'h00);
                                    resp_flush <= 1'b1;
                                    q_acc <= 1'b1;
                                    q_set <= 1'b1;
                                end else begin
                                    emit(`TOK_CMD_ABORT, 8'h00);
                                    err <= 1'b1;
                                end
                            end else begin
                                emit(`TOK_CMD_END, 8'h00);
                                q_acc <= kw_query;
                                q_set <= q_set | kw_query;
                            end
                        end
                        new_cmd;
                        pend_cmd <= 1'b0;
                        st <= pend_set ? S_ESET : S_FETCH;
                    end
                end
                S_ESET: begin
                    if (go) begin
                        if (set_has) begin
                            emit(`TOK_SET_END, 8'h00);
                        end
                        new_cmd;
                        err <= 1'b0;
                        set_has <= 1'b0;
                        pend_cmd <= 1'b0;
                        pend_set <= 1'b0;
                        q_set <= 1'b0;
                        st <= S_IDLE;
                    end
                end
                default: begin
                    st <= S_IDLE;
                end
            endcase
        end
    end

    // Response framing
    reg  [3:0]  tst;
    reg  [15:0] resp_cnt;
    wire        tx_load = !tx_valid || tx_ready;
    wire        tx_start = port_is_gpib ? talk_req : resp_pending;

    assign resp_ready = (tst == T_DATA) && tx_load;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tst <= T_IDLE;
            resp_cnt <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_eoi <= 1'b0;
            resp_pending <= 1'b0;
        end else begin
            if (tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (q_acc) begin
                resp_pending <= 1'b1;
            end else if ((tst == T_LF) && tx_load) begin
                resp_pending <= 1'b0;
            end
            case (tst)
                T_IDLE: begin
                    resp_cnt <= 16'h0000;
                    if (tx_start) begin
                        tst <= resp_pending ? T_DATA : T_CR;
                    end
                end
                T_DATA: begin
                    if (tx_load && resp_valid) begin
                        // Two places stay reserved for CR and LF
                        if (resp_cnt < (`RESP_MAX - 16'h0002)) begin
                            tx_valid <= 1'b1;
                            tx_data <= resp_data & 8'h7F;
                            tx_eoi <= 1'b0;
                            resp_cnt <= resp_cnt + 16'h0001;
                        end
                        if (resp_last) begin
                            tst <= T_CR;
                        end
                    end
                end
                T_CR: begin
                    if (tx_load) begin
                        tx_valid <= 1'b1;
                        tx_data <= `CH_CR;
                        tx_eoi <= 1'b0;
                        tst <= T_LF;
                    end
                end
                T_LF: begin
                    if (tx_load) begin
                        tx_valid <= 1'b1;
                        tx_data <= `CH_LF;
                        tx_eoi <= port_is_gpib;
                        tst <= T_IDLE;
                    end
                end
                default: begin
                    tst <= T_IDLE;
                end
            endcase
        end
    end

    // Local and remote arbitration
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            local_request <= 1'b0;
            remote_state <= 1'b0;
        end else begin
            local_request <= panel_local_req && remote_state;
            remote_state <= port_is_gpib ? gpib_remote : cmd_remote;
        end
    end
endmodule

// >>> bench/parser_chk.sv
// Port assertions for the command parser
`timescale 1ns/100ps
module parser_chk (
    input wire       clk,
    input wire       resetn,
    input wire       port_is_gpib,
    input wire [7:0] rx_data,
    input wire       rx_eoi,
    input wire       rx_valid,
    input wire       rx_ready,
    input wire       tok_valid,
    input wire       tok_ready,
    input wire [3:0] tok_kind,
    input wire [7:0] tok_data,
    input wire       resp_flush,
    input wire       tx_valid,
    input wire       tx_ready,
    input wire [7:0] tx_data,
    input wire       tx_eoi,
    input wire       gpib_remote,
    input wire       cmd_remote,
    input wire       panel_local_req,
    input wire       local_request,
    input wire       remote_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_local_follow: assert property ($past(resetn) |->
        local_request == $past(panel_local_req && remote_state)) else $error("local request");
    a_remote_source: assert property ($past(resetn) |->
        remote_state == $past(port_is_gpib ? gpib_remote : cmd_remote)) else $error("remote");
    a_tx_held: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable({tx_data, tx_eoi})) else $error("tx byte dropped");
    a_eoi_on_lf: assert property (tx_valid && tx_eoi |->
        tx_data == 8'h0A && port_is_gpib) else $error("end flag misplaced");
    a_lf_after_cr: assert property (tx_valid && tx_ready && tx_data == 8'h0D |->
        ##[1:4] tx_valid && tx_data == 8'h0A) else $error("no LF after CR");
    a_tok_held: assert property (tok_valid && !tok_ready |=>
        tok_valid && $stable({tok_kind, tok_data})) else $error("token dropped");
    a_eoi_stall: assert property (rx_valid && rx_ready && rx_eoi &&
        !(rx_data inside {8'h00, 8'h0A, 8'h0C, 8'h0D}) |=> !rx_ready) else $error("no stall");
    a_flush_gpib: assert property (resp_flush |-> port_is_gpib)
        else $error("flush off GPIB");
endmodule

// >>> bench/resp_sink.sv
// Host side model that takes response bytes with random stalls
`timescale 1ns/100ps
module resp_sink (
    input  wire       clk,
    input  wire       tx_valid,
    input  wire [7:0] tx_data,
    input  wire       tx_eoi,
    output reg        tx_ready,
    output reg        got,
    output reg  [8:0] got_byte
);
    initial begin
        tx_ready = 1'b0;
        got      = 1'b0;
        got_byte = 9'h000;
    end
    // Ready is raised at random, about two cycles in three, with no bound on a stall
    always @(posedge clk) begin
        got      <= tx_valid && tx_ready;
        got_byte <= {tx_eoi, tx_data};
        #1 tx_ready = ($urandom % 3) != 0;
    end
endmodule

// >>> bench/ascii_remote_command_parser_test.sv
// Self-checking bench for the command parser
`timescale 1ns/100ps
`include "cmd_parser_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %0t got %h want %h", $time, g, e); end end
module ascii_remote_command_parser_test;
    logic        clk = 0, resetn = 0, port_is_gpib = 0, rx_eoi = 0, rx_valid = 0;
    logic        tok_ready = 0, kw_class_valid = 0, talk_req = 0, gpib_remote = 0;
    logic        panel_local_req = 0, got, rx_ready, tok_valid, syntax_error, overrun_error;
    logic        resp_flush, resp_ready, tx_valid, tx_ready, tx_eoi, resp_pending;
    logic        local_request, remote_state, str_mode = 0, cmd_remote = 0;
    logic [7:0]  rx_data = 0, tok_data, tx_data, resp_data = "5";
    logic [3:0]  tok_kind;
    logic [1:0]  kw_class = 0;
    logic [8:0]  got_byte;
    logic [11:0] exp_tok[$];
    logic [8:0]  exp_tx[$];
    logic [1:0]  cls_q[$];
    int          bad_count = 0, samples_checked = 0, errs = 0, n;
    always #2 clk = ~clk;
    ascii_cmd_parser DUT (.clk(clk), .resetn(resetn), .port_is_gpib(port_is_gpib),
        .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tok_valid(tok_valid), .tok_ready(tok_ready), .tok_kind(tok_kind),
        .tok_data(tok_data), .kw_class_valid(kw_class_valid), .kw_class(kw_class),
        .str_mode(str_mode), .syntax_error(syntax_error), .overrun_error(overrun_error),
        .resp_flush(resp_flush), .talk_req(talk_req), .resp_data(resp_data),
        .resp_last(1'b1), .resp_valid(1'b1), .resp_ready(resp_ready), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_eoi(tx_eoi),
        .resp_pending(resp_pending), .gpib_remote(gpib_remote), .cmd_remote(cmd_remote),
        .panel_local_req(panel_local_req), .local_request(local_request),
        .remote_state(remote_state));
    resp_sink sink (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi),
                    .tx_ready(tx_ready), .got(got), .got_byte(got_byte));
    always @(posedge clk) begin
        errs += syntax_error + overrun_error;
        if (got) `CHK(got_byte, exp_tx.pop_front())
        if (tok_valid && tok_ready) begin
            `CHK({tok_kind, tok_data}, exp_tok.pop_front())
            if (tok_kind == `TOK_KW_END) begin
                kw_class_valid <= 1'b1;
                kw_class <= cls_q.pop_front();
            end else if (tok_kind != `TOK_KW_CHAR) kw_class_valid <= 1'b0;
        end
        #1 tok_ready = ($urandom % 4) != 0;
        panel_local_req = $urandom;
        gpib_remote = $urandom;
        cmd_remote = $urandom;
    end
    task give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic put(logic [7:0] b, bit eoi);
        rx_data = b;
        rx_eoi = eoi;
        rx_valid = 1'b1;
        for (n = 0; !rx_ready && n < 500; n++) @(posedge clk) #1;
        if (n == 500) begin
            bad_count++;
            give_verdict();
        end
        @(posedge clk) #1;
    endtask
    task automatic send(string s, bit eoi);
        for (int i = 0; i < s.len(); i++) put(s[i], eoi && i == s.len() - 1);
    endtask
    task automatic kw(string s, logic [7:0] q, logic [1:0] c);
        s = s.toupper();
        for (int i = 0; i < s.len(); i++) exp_tok.push_back({`TOK_KW_CHAR, s[i]});
        exp_tok.push_back({`TOK_KW_END, q});
        cls_q.push_back(c);
    endtask
    function void ex(logic [3:0] k, logic [7:0] d);
        exp_tok.push_back({k, d});
    endfunction
    task automatic settle(string name, int e);
        rx_valid = 1'b0;
        for (n = 0; (exp_tok.size() || exp_tx.size()) && n < 3000; n++) @(posedge clk);
        if (n == 3000) begin
            bad_count++;
            give_verdict();
        end
        repeat (20) @(posedge clk);
        #1;
        `CHK(errs, e)
        errs = 0;
        $display("test %s done", name);
    endtask
    task talk;
        talk_req = 1'b1;
        for (n = 0; !tx_valid && n < 500; n++) @(posedge clk) #1;
        talk_req = 1'b0;
        if (n == 500) begin
            bad_count++;
            give_verdict();
        end
    endtask
    initial begin
        void'($urandom(32'h70F53653));
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        resp_data = 8'h30 + $urandom % 10;
        kw("a?", 1, 0);
        ex(`TOK_CMD_END, 0);
        ex(`TOK_SET_END, 0);
        exp_tx = '{{1'b0, resp_data}, 9'h00D, 9'h00A};
        send("a?\n", 0);
        settle("serial query", 0);
        send("\n\r;;\f", 0);
        kw("b", 0, 0);
        ex(`TOK_FLD_CHAR, "c");
        ex(`TOK_SUB_SEP, ":");
        ex(`TOK_FLD_CHAR, "d");
        ex(`TOK_FLD_SEP, ",");
        ex(`TOK_FLD_CHAR, "e");
        ex(`TOK_CMD_END, 0);
        ex(`TOK_SET_END, 0);
        send("b,c:d,e", 0);
        put(8'h00, 0);
        settle("fields", 0);
        kw("k", 0, 0);
        ex(`TOK_CMD_END, 0);
        kw("x", 0, 1);
        ex(`TOK_CMD_ABORT, 0);
        ex(`TOK_SET_END, 0);
        send("k;x;y\r", 0);
        settle("error stops set", 1);
        kw("e", 0, 3);
        ex(`TOK_CMD_ABORT, 0);
        ex(`TOK_SET_END, 0);
        send("e\n", 0);
        settle("bus only", 1);
        port_is_gpib = 1'b1;
        exp_tx = '{9'h00D, 9'h10A};
        talk();
        settle("empty reply", 0);
        kw("q?", 1, 0);
        ex(`TOK_CMD_END, 0);
        ex(`TOK_SET_END, 0);
        send("q?", 1);
        settle("end flag", 0);
        `CHK(resp_pending, 1'b1)
        kw("r?", 1, 0);
        ex(`TOK_CMD_END, 0);
        ex(`TOK_SET_END, 0);
        send("r?\n", 0);
        settle("overlap", 1);
        exp_tx = '{{1'b0, resp_data}, 9'h00D, 9'h10A};
        talk();
        settle("reply", 0);
        `CHK(resp_pending, 1'b0)
        kw("l", 0, 2);
        ex(`TOK_CMD_ABORT, 0);
        kw("m", 0, 0);
        ex(`TOK_CMD_END, 0);
        ex(`TOK_SET_END, 0);
        send("l;m\n", 0);
        settle("panel command", 0);
        str_mode = 1'b1;
        kw("s", 0, 0);
        ex(`TOK_FLD_CHAR, "a");
        ex(`TOK_FLD_CHAR, `GLYPH_OMEGA);
        ex(`TOK_FLD_CHAR, ",");
        ex(`TOK_FLD_CHAR, ":");
        ex(`TOK_CMD_ABORT, 0);
        ex(`TOK_SET_END, 0);
        send("s,a!,:{\n", 0);
        settle("string field", 1);
        give_verdict();
    end
endmodule
bind ascii_cmd_parser parser_chk chk (.clk(clk), .resetn(resetn),
    .port_is_gpib(port_is_gpib), .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tok_valid(tok_valid), .tok_ready(tok_ready), .tok_kind(tok_kind),
    .tok_data(tok_data), .resp_flush(resp_flush), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_eoi(tx_eoi), .gpib_remote(gpib_remote), .cmd_remote(cmd_remote),
    .panel_local_req(panel_local_req), .local_request(local_request),
    .remote_state(remote_state));
